// ---- include/rtc_port_params.svh ----
/*
 * constants of the three-wire clock host port: format codes, widths, timing.
 * assumes inclusion by bare name from package and modules.
 */
`ifndef RTC_PORT_PARAMS_SVH
`define RTC_PORT_PARAMS_SVH

`define FMT_WRITE_ONE     4'h8
`define FMT_WRITE_BURST   4'h0
`define FMT_READ_ONE      4'hc
`define FMT_READ_BURST    4'h4
`define ADDR_TOP          4'hf
`define CLK_HZ            40000000
`define REF_HZ            32768
`define REF_FRAC_W        32
`define REF_STEP          32'h0035afe5
`define CARRY_HOLD_MS     1000
`define CARRY_HOLD_CYCLES 40000000

`endif

// ---- include/rtc_port_pkg.sv ----
/*
 * types of the three-wire clock host port.
 * assumes rtc_port_params.svh on the include path.
 */
`include "rtc_port_params.svh"
package rtc_port_pkg;
   typedef enum logic [1:0] {
      PH_CMD,
      PH_WRITE,
      PH_READ
   } phase_t;
   typedef logic [3:0] addr_t;
   typedef logic [7:0] byte_t;
endpackage

// ---- src/ref_clock_gen.sv ----
/*
 * phase accumulator making a 32.768 kHz square wave from the system clock.
 * assumes clk_i at 40 MHz; output is a registered level.
 */
`timescale 1ns/1ps
`include "rtc_port_params.svh"
module ref_clock_gen (
   input  wire logic clk_i,
   input  wire logic resetn_i,
   output logic      ref_o
);
   logic [`REF_FRAC_W-1:0] acc;
   logic [`REF_FRAC_W-1:0] next_acc;

   // msb runs one full period per 2^32 / step clocks; jitter is one clock
   always_comb begin
      next_acc = acc + `REF_STEP;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         acc   <= '0;
         ref_o <= 1'b0;
      end else begin
         acc   <= next_acc;
         ref_o <= next_acc[`REF_FRAC_W-1];
      end
   end
endmodule

// ---- src/three_wire_rtc_host_port.sv ----
/*
 * three-wire serial host port of a real-time clock: command decode, single and
 * burst read/write of 16 byte registers, seconds-carry hold, reference clock.
 * assumes chip select, serial clock and data in are synchronous to clk_i; the
 * register file itself sits outside and answers reg_rdata_i combinationally.
 */
// Behaviour
// - format 4h starts burst read from the address in the command byte's high nibble
// - burst address steps by one per byte, wraps Fh to 0h
// - burst read runs until chip select falls; driving stops then
// - single read and single write may chain in one session
// - formats: 8h single write, 0h burst write, Ch single read, 4h burst read
// - carry into seconds held while selected, for one second at most, released on chip select fall
// - reference output carries a continuous 32.768 kHz square wave
// - command byte: address high nibble, format low nibble, msb first
// - clock level at select rise picks the edges for output and input
// - session spans select high; data moves in whole bytes
// - after single write a fresh command byte is accepted
`timescale 1ns/1ps
`include "rtc_port_params.svh"
module three_wire_rtc_host_port
   import rtc_port_pkg::*;
#(
   parameter int CARRY_HOLD_CYCLES = `CARRY_HOLD_CYCLES
) (
   input  wire logic       clk_i,
   input  wire logic       resetn_i,
   input  wire logic       chip_select_i,
   input  wire logic       serial_clock_i,
   input  wire logic       serial_data_i,
   output logic            serial_data_o,
   output logic            serial_data_oe_o,
   output logic [3:0]      reg_addr_o,
   output logic [7:0]      reg_wdata_o,
   output logic            reg_write_o,
   input  wire logic [7:0] reg_rdata_i,
   input  wire logic       seconds_carry_i,
   output logic            seconds_carry_o,
   output logic            carry_held_o,
   output logic            reference_clock_out_o
);
   logic   cs_q;
   logic   sclk_q;
   logic   invert;
   phase_t phase;
   logic   burst;
   addr_t  addr;
   byte_t  shift_in;
   logic [2:0] bits;
   byte_t  shift_out;
   logic   carry_pend;
   logic [25:0] hold_cnt;
   logic   load;

   logic   next_invert;
   phase_t next_phase;
   logic   next_burst;
   addr_t  next_addr;
   byte_t  next_shift_in;
   logic [2:0] next_bits;
   byte_t  next_shift_out;
   logic   next_carry_pend;
   logic [25:0] next_hold_cnt;
   logic   next_load;
   addr_t  next_reg_addr;
   logic   next_sdo;
   logic   next_oe;
   logic   next_we;
   byte_t  next_wdata;
   logic   next_carry_out;

   logic cs_rise;
   logic cs_fall;
   logic rise;
   logic fall;
   logic take_edge;
   logic shift_edge;
   byte_t rx_byte;

   always_comb begin
      cs_rise = chip_select_i && !cs_q;
      cs_fall = !chip_select_i && cs_q;
      rise    = serial_clock_i && !sclk_q;
      fall    = !serial_clock_i && sclk_q;
      // low clock at select rise: output on rise, input on fall; else swapped
      take_edge  = invert ? rise : fall;
      shift_edge = invert ? fall : rise;
      rx_byte    = {shift_in[6:0], serial_data_i};
   end

   always_comb begin
      next_invert     = invert;
      next_phase      = phase;
      next_burst      = burst;
      next_addr       = addr;
      next_shift_in   = shift_in;
      next_bits       = bits;
      next_shift_out  = shift_out;
      next_carry_pend = carry_pend;
      next_hold_cnt   = hold_cnt;
      next_sdo        = serial_data_o;
      next_oe         = serial_data_oe_o;
      next_we         = 1'b0;
      next_wdata      = reg_wdata_o;
      next_carry_out  = 1'b0;
      next_load       = 1'b0;

      // carry arriving while selected waits for the select to drop
      if (seconds_carry_i) begin
         if (chip_select_i && hold_cnt < 26'(CARRY_HOLD_CYCLES)) begin
            next_carry_pend = 1'b1;
         end else begin
            next_carry_out = 1'b1;
         end
      end
      if (chip_select_i && carry_pend) begin
         next_hold_cnt = hold_cnt + 26'd1;
         // the hold lasts one second at most; beyond that the carry goes through
         if (hold_cnt >= 26'(CARRY_HOLD_CYCLES - 1)) begin
            next_carry_out  = 1'b1;
            // a carry arriving in the release cycle stays held, not lost
            next_carry_pend = seconds_carry_i && hold_cnt < 26'(CARRY_HOLD_CYCLES);
         end
      end

      if (cs_rise) begin
         next_invert = serial_clock_i;
         next_phase  = PH_CMD;
         next_bits   = 3'd0;
         next_oe     = 1'b0;
      end else if (!chip_select_i) begin
         next_phase = PH_CMD;
         next_oe    = 1'b0;
         next_bits  = 3'd0;
         if (carry_pend) begin
            next_carry_out  = 1'b1;
            // a carry arriving now goes out one cycle later, so none merge
            next_carry_pend = seconds_carry_i;
         end
         next_hold_cnt = '0;
      end else begin
         // reg_addr_o settles one cycle after the pointer moves; fetch then.
         // needs serial clock half periods of two clocks or more
         if (load) begin
            next_shift_out = reg_rdata_i;
         end
         if (shift_edge && phase == PH_READ) begin
            next_sdo       = shift_out[7];
            next_shift_out = {shift_out[6:0], 1'b0};
         end
         if (take_edge) begin
            next_shift_in = rx_byte;
            next_bits     = bits + 3'd1;
            if (bits == 3'd7) begin
               unique case (phase)
                  PH_CMD: begin
                     next_addr = rx_byte[7:4];
                     unique case (rx_byte[3:0])
                        `FMT_WRITE_ONE: begin
                           next_phase = PH_WRITE;
                           next_burst = 1'b0;
                        end
                        `FMT_WRITE_BURST: begin
                           next_phase = PH_WRITE;
                           next_burst = 1'b1;
                        end
                        `FMT_READ_ONE: begin
                           next_phase = PH_READ;
                           next_burst = 1'b0;
                        end
                        `FMT_READ_BURST: begin
                           next_phase = PH_READ;
                           next_burst = 1'b1;
                        end
                        default: next_phase = PH_CMD;
                     endcase
                     if (next_phase == PH_READ) begin
                        next_oe   = 1'b1;
                        next_load = 1'b1;
                     end
                  end
                  PH_WRITE: begin
                     next_we    = 1'b1;
                     next_wdata = rx_byte;
                     if (burst) begin
                        next_addr = addr + 4'd1;
                     end else begin
                        next_phase = PH_CMD;
                     end
                  end
                  PH_READ: begin
                     if (burst) begin
                        next_addr = addr + 4'd1;
                        next_load = 1'b1;
                     end else begin
                        next_phase = PH_CMD;
                        next_oe    = 1'b0;
                     end
                  end
                  default: next_phase = PH_CMD;
               endcase
            end
         end
      end
      // a write leaves with the address it aimed at, before the pointer steps
      next_reg_addr = (phase == PH_WRITE) ? addr : next_addr;
   end

   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cs_q             <= 1'b0;
         sclk_q           <= 1'b0;
         invert           <= 1'b0;
         phase            <= PH_CMD;
         burst            <= 1'b0;
         addr             <= 4'h0;
         shift_in         <= 8'h00;
         bits             <= 3'd0;
         shift_out        <= 8'h00;
         carry_pend       <= 1'b0;
         hold_cnt         <= '0;
         load             <= 1'b0;
         serial_data_o    <= 1'b0;
         serial_data_oe_o <= 1'b0;
         reg_addr_o       <= 4'h0;
         reg_wdata_o      <= 8'h00;
         reg_write_o      <= 1'b0;
         seconds_carry_o  <= 1'b0;
         carry_held_o     <= 1'b0;
      end else begin
         cs_q             <= chip_select_i;
         sclk_q           <= serial_clock_i;
         invert           <= next_invert;
         phase            <= next_phase;
         burst            <= next_burst;
         addr             <= next_addr;
         shift_in         <= next_shift_in;
         bits             <= next_bits;
         shift_out        <= next_shift_out;
         carry_pend       <= next_carry_pend;
         hold_cnt         <= next_hold_cnt;
         load             <= next_load;
         serial_data_o    <= next_sdo;
         serial_data_oe_o <= next_oe;
         reg_addr_o       <= next_reg_addr;
         reg_wdata_o      <= next_wdata;
         reg_write_o      <= next_we;
         seconds_carry_o  <= next_carry_out;
         carry_held_o     <= next_carry_pend;
      end
   end

   ref_clock_gen u_ref (
      .clk_i    (clk_i),
      .resetn_i (resetn_i),
      .ref_o    (reference_clock_out_o)
   );
endmodule

// ---- verification/rtc_port_chk.sv ----
/* assertions on the pins of the three-wire clock port.
   assumes one clock domain and a bind to three_wire_rtc_host_port. */
`timescale 1ns/1ps
module rtc_port_chk (
   input wire logic       clk_i,
   input wire logic       resetn_i,
   input wire logic       chip_select_i,
   input wire logic       seconds_carry_i,
   input wire logic       serial_data_oe_o,
   input wire logic [3:0] reg_addr_o,
   input wire logic       reg_write_o,
   input wire logic       seconds_carry_o,
   input wire logic       carry_held_o,
   input wire logic       reference_clock_out_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   sequence s_ref_edge;
      $changed(reference_clock_out_o);
   endsequence
   sequence s_idle;
      !chip_select_i [*4];
   endsequence
   // 40 MHz / 65536 gives 610 or 611 cycles per half wave
   property p_ref;
      s_ref_edge |=> $stable(reference_clock_out_o) [*8] ##[602:603] s_ref_edge;
   endproperty
   property p_oe_idle;
      s_idle |-> !serial_data_oe_o;
   endproperty
   property p_wr_idle;
      s_idle |-> !reg_write_o;
   endproperty
   property p_wr_quiet;
      reg_write_o |-> !serial_data_oe_o;
   endproperty
   property p_step;
      serial_data_oe_o && $past(serial_data_oe_o) && $changed(reg_addr_o)
         |-> reg_addr_o == $past(reg_addr_o) + 4'h1;
   endproperty
   property p_hold;
      chip_select_i [*3] ##0 seconds_carry_i |=> carry_held_o;
   endproperty
   property p_hold_quiet;
      chip_select_i [*3] |-> !seconds_carry_o;
   endproperty
   property p_release;
      $fell(chip_select_i) && carry_held_o |-> ##[1:4] seconds_carry_o;
   endproperty
   a_ref: assert property (p_ref) else $error("reference half wave off");
   a_oe_idle: assert property (p_oe_idle) else $error("drive while idle");
   a_wr_idle: assert property (p_wr_idle) else $error("write while idle");
   a_wr_quiet: assert property (p_wr_quiet) else $error("write while driving");
   a_step: assert property (p_step) else $error("burst address step");
   a_hold: assert property (p_hold) else $error("carry not held");
   a_hold_quiet: assert property (p_hold_quiet) else $error("carry leaked");
   a_release: assert property (p_release) else $error("carry not released");
endmodule
bind three_wire_rtc_host_port rtc_port_chk rtc_port_chk_inst (
   .clk_i(clk_i), .resetn_i(resetn_i), .chip_select_i(chip_select_i),
   .seconds_carry_i(seconds_carry_i), .serial_data_oe_o(serial_data_oe_o),
   .reg_addr_o(reg_addr_o), .reg_write_o(reg_write_o), .seconds_carry_o(seconds_carry_o),
   .carry_held_o(carry_held_o), .reference_clock_out_o(reference_clock_out_o));

// ---- verification/host_cpu_model.sv ----
/* host cpu model driving select, serial clock and the shared data line.
   assumes clk_i at 40 MHz and the port's data and enable on data_i, oe_i. */
`timescale 1ns/1ps
module host_cpu_model
   import rtc_port_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic data_i,
   input  wire logic oe_i,
   output logic      select_o,
   output logic      sclk_o,
   output logic      line_o
);
   logic idle = 1'b0;
   logic drv = 1'b0;
   logic bit_v = 1'b0;
   // a released line shows the inverse of its last bit, never a stale copy
   assign line_o = oe_i ? data_i : (drv ? bit_v : ~bit_v);
   initial select_o = 1'b0;
   initial sclk_o = 1'b0;
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #2;
   endtask
   task automatic open_session(input logic lvl);
      sclk_o = lvl;
      idle = lvl;
      step(4);
      select_o = 1'b1;
      step(1240);
   endtask
   task automatic close_session;
      step(4);
      select_o = 1'b0;
      drv = 1'b0;
      step(2480);
   endtask
   task automatic xfer(input byte_t tx, input logic send, input int n, output byte_t rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sclk_o = ~idle;
         step(4);
         rx[i] = line_o;
         drv = send;
         bit_v = tx[i];
         step(4);
         sclk_o = idle;
         step(4);
      end
   endtask
endmodule

// ---- verification/three_wire_rtc_host_port_tb.sv ----
/* self-checking bench of the three-wire clock port with a register file.
   assumes host_cpu_model as the far side and rtc_port_chk bound in. */
`timescale 1ns/1ps
module three_wire_rtc_host_port_tb
   import rtc_port_pkg::*;
;
   logic clk_i;
   logic resetn_i;
   logic cs, sclk, line, sdo, oe, wr, cin, cout, held, refc;
   addr_t addr;
   byte_t wdata;
   byte_t regs [16];
   int errors = 0;
   int compares = 0;
   int pulses = 0;
   always #12.5 clk_i = ~clk_i;
   initial for (int i = 0; i < 16; i++) regs[i] = 8'h40 + 8'(i);
   always @(posedge clk_i) if (wr === 1'b1) regs[addr] <= wdata;
   always @(posedge clk_i) if (cout === 1'b1) pulses++;
   host_cpu_model host_cpu_model_inst (.clk_i(clk_i), .data_i(sdo), .oe_i(oe),
      .select_o(cs), .sclk_o(sclk), .line_o(line));
   three_wire_rtc_host_port #(.CARRY_HOLD_CYCLES(400)) three_wire_rtc_host_port_inst (
      .clk_i(clk_i), .resetn_i(resetn_i), .chip_select_i(cs), .serial_clock_i(sclk),
      .serial_data_i(line), .serial_data_o(sdo), .serial_data_oe_o(oe), .reg_addr_o(addr),
      .reg_wdata_o(wdata), .reg_write_o(wr), .reg_rdata_i(regs[addr]), .seconds_carry_i(cin),
      .seconds_carry_o(cout), .carry_held_o(held), .reference_clock_out_o(refc));
   task automatic chk(input string what, input byte_t exp, input byte_t got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("unexpected %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic t_chain(input logic lvl, input byte_t v);
      byte_t r;
      host_cpu_model_inst.open_session(lvl);
      host_cpu_model_inst.xfer(8'hff, 1'b1, 3, r);
      host_cpu_model_inst.close_session; // partial byte dropped
      host_cpu_model_inst.open_session(lvl);
      host_cpu_model_inst.xfer(8'h38, 1'b1, 8, r);
      host_cpu_model_inst.xfer(v, 1'b1, 8, r);
      host_cpu_model_inst.xfer(8'h3c, 1'b1, 8, r);
      host_cpu_model_inst.xfer(8'h00, 1'b0, 8, r);
      chk("single read", v, r);
      host_cpu_model_inst.xfer(8'h4c, 1'b1, 8, r);
      host_cpu_model_inst.xfer(8'h00, 1'b0, 8, r);
      chk("read after read", 8'h44, r);
      host_cpu_model_inst.close_session;
      $display("test chain done");
   endtask
   task automatic t_burst;
      byte_t r;
      host_cpu_model_inst.open_session(1'b0);
      host_cpu_model_inst.xfer(8'he0, 1'b1, 8, r);
      for (int i = 1; i <= 3; i++) host_cpu_model_inst.xfer(8'(i * 17), 1'b1, 8, r);
      host_cpu_model_inst.close_session;
      chk("reg e", 8'h11, regs[14]);
      chk("reg 0", 8'h33, regs[0]);
      host_cpu_model_inst.open_session(1'b0);
      host_cpu_model_inst.xfer(8'hf4, 1'b1, 8, r);
      for (int i = 0; i < 3; i++) begin
         host_cpu_model_inst.xfer(8'h00, 1'b0, 8, r);
         chk("burst read", i == 2 ? 8'h41 : 8'(34 + i * 17), r);
      end
      host_cpu_model_inst.close_session;
      chk("oe after close", 8'h00, {7'h0, oe});
      $display("test burst done");
   endtask
   task automatic t_carry;
      host_cpu_model_inst.open_session(1'b0);
      cin = 1'b1;
      host_cpu_model_inst.step(1);
      cin = 1'b0;
      host_cpu_model_inst.step(3);
      chk("held", 8'h01, {7'h0, held});
      chk("early carries", 8'h00, 8'(pulses));
      host_cpu_model_inst.close_session;
      chk("released carries", 8'h01, 8'(pulses));
      $display("test carry done");
   endtask
   task automatic t_ref;
      int n;
      n = 0;
      @(posedge refc);
      while (refc === 1'b1) begin
         host_cpu_model_inst.step(1);
         n++;
      end
      // 40 MHz over twice 32.768 kHz: 610 or 611 clocks per half wave
      chk("ref half wave", 8'h01, {7'h0, (n inside {610, 611})});
      $display("test ref done");
   endtask
   task automatic summarize;
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #(25 * 60000);
      errors++;
      summarize;
   end
   initial begin
      clk_i = 1'b0;
      resetn_i = 1'b0;
      cin = 1'b0;
      repeat (4) @(posedge clk_i);
      #2 resetn_i = 1'b1;
      host_cpu_model_inst.step(2);
      t_chain(1'b0, 8'ha5);
      t_chain(1'b1, 8'h5a);
      t_burst;
      t_carry;
      t_ref;
      summarize;
   end
endmodule
